// ---- src/mmpt_timer.sv ----
// advanced motor-control timer: counter, four channels, dead-time pairs
// assumes configuration is static while used and all pins synchronous
`timescale 1ns/1ps
module mmpt_timer (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // configuration
   input wire mmpt_pkg::mmpt_cfg_t cfg_i,
   input wire mmpt_pkg::mmpt_ch_cfg_t [mmpt_pkg::NUM_CH-1:0] ch_cfg_i,
   // pins and links
   input wire logic [mmpt_pkg::NUM_CH-1:0] ch_in_i,
   input wire logic ext_trig_i,
   input wire logic link_trig_i,
   // channel outputs
   output logic [mmpt_pkg::NUM_CH-1:0] ch_out_o,
   output logic [mmpt_pkg::NUM_PAIR-1:0] ch_out_n_o,
   // captures
   output logic [mmpt_pkg::CNT_W-1:0] cap_val_o [mmpt_pkg::NUM_CH],
   output logic [mmpt_pkg::NUM_CH-1:0] cap_stb_o,
   // status
   output logic [mmpt_pkg::CNT_W-1:0] count_o,
   output logic dir_o,
   output logic running_o,
   output logic update_o,
   output logic trig_out_o
);

   localparam int W = mmpt_pkg::CNT_W;
   localparam int N = mmpt_pkg::NUM_CH;
   localparam int P = mmpt_pkg::NUM_PAIR;

   // rising edge of a level against its previous sample
   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction

   mmpt_pkg::mmpt_state_t st_r, st_nxt;
   logic [W-1:0] cnt_r, cnt_nxt;
   logic [W-1:0] psc_r, psc_nxt;
   logic dir_r, dir_nxt;
   logic upd_r, upd_nxt;
   logic stp_r, stp_nxt;
   logic trig_prev_r;
   logic trig_lvl, trig_edge, tick, cnt_en;
   logic q_inc, q_dec;
   logic [N-1:0] in_prev_r;
   logic [N-1:0] ref_r, ref_nxt;
   logic [N-1:0] stb_r, stb_nxt;
   logic [W-1:0] cap_r [N];
   logic [W-1:0] cap_nxt [N];
   logic [P-1:0] pair_hi, pair_lo;
   logic out3_r;

   // trigger source: pin or a sibling timer's link
   assign trig_lvl = (cfg_i.trig_sel ? link_trig_i : ext_trig_i) ^ cfg_i.trig_pol;
   assign trig_edge = rise(trig_lvl, trig_prev_r);
   assign tick = (psc_r == cfg_i.prescale);

   // encoder uses channel inputs 0 and 1 as phases
   mmpt_quad_dec u_quad (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .pha_i(ch_in_i[0]),
      .phb_i(ch_in_i[1]),
      .inc_o(q_inc),
      .dec_o(q_dec)
   );

   // run state and time base
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      psc_nxt = psc_r;
      dir_nxt = dir_r;
      upd_nxt = 1'b0;
      stp_nxt = 1'b0;
      cnt_en = 1'b0;
      unique case (st_r)
         mmpt_pkg::MMPT_ST_IDLE:
         begin
            psc_nxt = '0;
            if (cfg_i.enable && cfg_i.slave != mmpt_pkg::MMPT_SLV_START)
            begin
               st_nxt = mmpt_pkg::MMPT_ST_RUN;
            end
            else if (cfg_i.enable && trig_edge)
            begin
               st_nxt = mmpt_pkg::MMPT_ST_RUN;
               cnt_nxt = mmpt_pkg::CNT_RST;
               dir_nxt = 1'b0;
            end
         end
         mmpt_pkg::MMPT_ST_RUN:
         begin
            if (cfg_i.slave == mmpt_pkg::MMPT_SLV_ENC)
            begin
               if (q_inc)
               begin
                  cnt_nxt = (cnt_r == cfg_i.period) ? '0 : cnt_r + 1'b1;
                  dir_nxt = 1'b0;
                  stp_nxt = 1'b1;
               end
               else if (q_dec)
               begin
                  cnt_nxt = (cnt_r == '0) ? cfg_i.period : cnt_r - 1'b1;
                  dir_nxt = 1'b1;
                  stp_nxt = 1'b1;
               end
            end
            else if (cfg_i.slave == mmpt_pkg::MMPT_SLV_RESET && trig_edge)
            begin
               cnt_nxt = '0;
               psc_nxt = '0;
               dir_nxt = 1'b0;
               upd_nxt = 1'b1;
               stp_nxt = 1'b1;
            end
            else
            begin
               // gate mode freezes the prescaler too, so no partial tick leaks
               cnt_en = (cfg_i.slave != mmpt_pkg::MMPT_SLV_GATE) || trig_lvl;
               if (cnt_en)
               begin
                  psc_nxt = tick ? '0 : psc_r + 1'b1;
               end
               if (cnt_en && tick)
               begin
                  stp_nxt = 1'b1;
                  if (cfg_i.cnt_mode == mmpt_pkg::MMPT_EDGE)
                  begin
                     dir_nxt = 1'b0;
                     if (cnt_r >= cfg_i.period)
                     begin
                        cnt_nxt = '0;
                        upd_nxt = 1'b1;
                     end
                     else
                     begin
                        cnt_nxt = cnt_r + 1'b1;
                     end
                  end
                  else if (!dir_r)
                  begin
                     if (cnt_r >= cfg_i.period)
                     begin
                        dir_nxt = (cfg_i.period != '0);
                        cnt_nxt = (cfg_i.period != '0) ? cfg_i.period - 1'b1 : '0;
                        upd_nxt = 1'b1;
                     end
                     else
                     begin
                        cnt_nxt = cnt_r + 1'b1;
                     end
                  end
                  else if (cnt_r == '0)
                  begin
                     dir_nxt = 1'b0;
                     cnt_nxt = (cfg_i.period != '0) ? 16'h0001 : '0;
                     upd_nxt = 1'b1;
                  end
                  else
                  begin
                     cnt_nxt = cnt_r - 1'b1;
                  end
               end
            end
            if (!cfg_i.enable)
            begin
               st_nxt = mmpt_pkg::MMPT_ST_IDLE;
            end
            else if (cfg_i.one_pulse && upd_nxt)
            begin
               st_nxt = mmpt_pkg::MMPT_ST_DONE;
            end
         end
         mmpt_pkg::MMPT_ST_DONE:
         begin
            // single pulse over: counter stopped until a new start
            psc_nxt = '0;
            if (!cfg_i.enable)
            begin
               st_nxt = mmpt_pkg::MMPT_ST_IDLE;
            end
            else if (cfg_i.slave == mmpt_pkg::MMPT_SLV_START && trig_edge)
            begin
               st_nxt = mmpt_pkg::MMPT_ST_RUN;
               cnt_nxt = '0;
               dir_nxt = 1'b0;
            end
         end
         default:
         begin
            st_nxt = mmpt_pkg::MMPT_ST_IDLE;
         end
      endcase
   end

   // time base registers
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         st_r <= mmpt_pkg::MMPT_ST_IDLE;
         cnt_r <= mmpt_pkg::CNT_RST;
         psc_r <= '0;
         dir_r <= 1'b0;
         upd_r <= 1'b0;
         stp_r <= 1'b0;
         trig_prev_r <= 1'b1; // a level already high at release is not taken as an edge
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         psc_r <= psc_nxt;
         dir_r <= dir_nxt;
         upd_r <= upd_nxt;
         stp_r <= stp_nxt;
         trig_prev_r <= trig_lvl;
      end
   end

   // per-channel capture, compare and pwm; no channel reads another's setting
   always_comb
   begin
      stb_nxt = '0;
      ref_nxt = ref_r;
      for (int i = 0; i < N; i++)
      begin
         cap_nxt[i] = cap_r[i];
         unique case (ch_cfg_i[i].mode)
            mmpt_pkg::MMPT_CH_CAPTURE:
            begin
               ref_nxt[i] = 1'b0;
               // both edges give the pulse width as a difference of captures
               if (ch_cfg_i[i].both_edges ? (ch_in_i[i] != in_prev_r[i]) :
                   (ch_cfg_i[i].pol ? rise(in_prev_r[i], ch_in_i[i]) : rise(ch_in_i[i], in_prev_r[i])))
               begin
                  cap_nxt[i] = cnt_r;
                  stb_nxt[i] = 1'b1;
               end
            end
            mmpt_pkg::MMPT_CH_COMPARE:
            begin
               if (st_r != mmpt_pkg::MMPT_ST_RUN)
               begin
                  ref_nxt[i] = ch_cfg_i[i].pol;
               end
               else if (stp_r && cnt_r == ch_cfg_i[i].cmp)
               begin
                  ref_nxt[i] = ~ref_r[i];
               end
            end
            mmpt_pkg::MMPT_CH_PWM:
            begin
               // stopped counter parks output low whatever its pol setting
               ref_nxt[i] = (st_r == mmpt_pkg::MMPT_ST_RUN) &&
                            ((cnt_r < ch_cfg_i[i].cmp) ^ ch_cfg_i[i].pol);
            end
            default:
            begin
               ref_nxt[i] = 1'b0;
            end
         endcase
      end
   end

   // channel registers
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         in_prev_r <= '0;
         ref_r <= '0;
         stb_r <= '0;
         out3_r <= 1'b0;
         for (int i = 0; i < N; i++)
         begin
            cap_r[i] <= mmpt_pkg::CNT_RST;
         end
      end
      else
      begin
         in_prev_r <= ch_in_i;
         ref_r <= ref_nxt;
         stb_r <= stb_nxt;
         out3_r <= ref_r[N-1];
         for (int i = 0; i < N; i++)
         begin
            cap_r[i] <= cap_nxt[i];
         end
      end
   end

   // three phases on six pins, each pair with dead-time
   for (genvar g = 0; g < P; g++)
   begin : g_pair
      mmpt_deadtime #(
         .DT_W(mmpt_pkg::DT_W)
      ) u_dt (
         .ref_clk_i(ref_clk_i),
         .srst_i(srst_i),
         .en_i(cfg_i.enable && ch_cfg_i[g].mode != mmpt_pkg::MMPT_CH_CAPTURE),
         .ref_i(ref_r[g]),
         .dt_i(cfg_i.dead_time),
         .hi_o(pair_hi[g]),
         .lo_o(pair_lo[g])
      );
   end

   // outputs, all from flops except running_o, decoded from st_r
   assign ch_out_o = {out3_r, pair_hi};
   assign ch_out_n_o = pair_lo;
   assign cap_val_o = cap_r;
   assign cap_stb_o = stb_r;
   assign count_o = cnt_r;
   assign dir_o = dir_r;
   assign running_o = (st_r == mmpt_pkg::MMPT_ST_RUN);
   assign update_o = upd_r;
   assign trig_out_o = upd_r;

endmodule

// ---- src/mmpt_pkg.sv ----
// motor pwm timer package: widths, modes, configuration structs
// assumes a single clock domain and configuration held stable by the system
package mmpt_pkg;

   localparam int CNT_W = 16;
   localparam int NUM_CH = 4;
   localparam int NUM_PAIR = 3;
   localparam int DT_W = 8;

   // reset values of counter state
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [DT_W-1:0] DT_RST = 8'h00;

   // counting shape of the time base
   typedef enum logic
   {
      MMPT_EDGE = 1'b0,
      MMPT_CENTER = 1'b1
   } mmpt_cnt_mode_t;

   // how the trigger acts on the counter
   typedef enum logic [2:0]
   {
      MMPT_SLV_OFF = 3'h0,
      MMPT_SLV_RESET = 3'h1,
      MMPT_SLV_GATE = 3'h2,
      MMPT_SLV_START = 3'h3,
      MMPT_SLV_ENC = 3'h4
   } mmpt_slave_t;

   // per-channel function
   typedef enum logic [1:0]
   {
      MMPT_CH_CAPTURE = 2'h0,
      MMPT_CH_COMPARE = 2'h1,
      MMPT_CH_PWM = 2'h2
   } mmpt_ch_mode_t;

   // run state, gray along idle -> run -> done
   typedef enum logic [1:0]
   {
      MMPT_ST_IDLE = 2'b00,
      MMPT_ST_RUN = 2'b01,
      MMPT_ST_DONE = 2'b11
   } mmpt_state_t;

   // timer-wide configuration
   typedef struct packed
   {
      logic enable;
      mmpt_cnt_mode_t cnt_mode;
      logic one_pulse;
      mmpt_slave_t slave;
      logic trig_sel;
      logic trig_pol;
      logic [CNT_W-1:0] period;
      logic [CNT_W-1:0] prescale;
      logic [DT_W-1:0] dead_time;
   } mmpt_cfg_t;

   // one channel's configuration
   typedef struct packed
   {
      mmpt_ch_mode_t mode;
      logic pol;
      logic both_edges;
      logic [CNT_W-1:0] cmp;
   } mmpt_ch_cfg_t;

endpackage

// ---- src/mmpt_deadtime.sv ----
// complementary output pair with dead-time insertion
// assumes ref_i is registered in the same clock domain
`timescale 1ns/1ps
module mmpt_deadtime #(
   parameter int DT_W = 8
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // control
   input wire logic en_i,
   input wire logic ref_i,
   input wire logic [DT_W-1:0] dt_i,
   // pair outputs
   output logic hi_o,
   output logic lo_o
);

   logic prev_r, prev_nxt;
   logic [DT_W-1:0] cnt_r, cnt_nxt;
   logic hi_r, hi_nxt;
   logic lo_r, lo_nxt;

   // any change of the reference first drops both sides
   always_comb
   begin
      prev_nxt = prev_r;
      cnt_nxt = cnt_r;
      hi_nxt = hi_r;
      lo_nxt = lo_r;
      if (!en_i)
      begin
         prev_nxt = ref_i;
         cnt_nxt = dt_i;
         hi_nxt = 1'b0;
         lo_nxt = 1'b0;
      end
      else if (ref_i != prev_r)
      begin
         prev_nxt = ref_i;
         cnt_nxt = dt_i;
         hi_nxt = 1'b0;
         lo_nxt = 1'b0;
      end
      else if (cnt_r != '0)
      begin
         cnt_nxt = cnt_r - 1'b1;
      end
      else
      begin
         hi_nxt = prev_r;
         lo_nxt = ~prev_r;
      end
   end

   // registers; both low out of reset
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         prev_r <= 1'b0;
         cnt_r <= '0;
         hi_r <= 1'b0;
         lo_r <= 1'b0;
      end
      else
      begin
         prev_r <= prev_nxt;
         cnt_r <= cnt_nxt;
         hi_r <= hi_nxt;
         lo_r <= lo_nxt;
      end
   end

   assign hi_o = hi_r;
   assign lo_o = lo_r;

endmodule

// ---- src/mmpt_quad_dec.sv ----
// quadrature decoder, four counts per encoder cycle
// assumes phase inputs already synchronous to the clock
`timescale 1ns/1ps
module mmpt_quad_dec (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // encoder phases
   input wire logic pha_i,
   input wire logic phb_i,
   // step pulses
   output logic inc_o,
   output logic dec_o
);

   logic pha_r, phb_r;
   logic inc_r, inc_nxt;
   logic dec_r, dec_nxt;
   logic cha, chb;

   // one phase moving decides direction; both at once is unresolvable and ignored
   always_comb
   begin
      cha = pha_i ^ pha_r;
      chb = phb_i ^ phb_r;
      inc_nxt = 1'b0;
      dec_nxt = 1'b0;
      if (cha ^ chb)
      begin
         inc_nxt = pha_r ^ phb_i;
         dec_nxt = ~(pha_r ^ phb_i);
      end
   end

   // phase history and registered steps
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         pha_r <= 1'b0;
         phb_r <= 1'b0;
         inc_r <= 1'b0;
         dec_r <= 1'b0;
      end
      else
      begin
         pha_r <= pha_i;
         phb_r <= phb_i;
         inc_r <= inc_nxt;
         dec_r <= dec_nxt;
      end
   end

   assign inc_o = inc_r;
   assign dec_o = dec_r;

endmodule

// ---- tb/mmpt_timer_sva.sv ----
// checker for the motor pwm timer, watching the top ports only
// assumes one clock and configuration held while out of reset
`timescale 1ns/1ps
module mmpt_timer_sva (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // inputs watched
   input wire mmpt_pkg::mmpt_cfg_t cfg_i,
   input wire mmpt_pkg::mmpt_ch_cfg_t [mmpt_pkg::NUM_CH-1:0] ch_cfg_i,
   input wire logic [mmpt_pkg::NUM_CH-1:0] ch_in_i,
   input wire logic ext_trig_i,
   input wire logic link_trig_i,
   // outputs watched
   input wire logic [mmpt_pkg::NUM_CH-1:0] ch_out_o,
   input wire logic [mmpt_pkg::NUM_PAIR-1:0] ch_out_n_o,
   input wire logic [mmpt_pkg::NUM_CH-1:0] cap_stb_o,
   input wire logic [mmpt_pkg::CNT_W-1:0] count_o,
   input wire logic running_o,
   input wire logic update_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   logic trg;
   logic free_edge;
   logic [7:0] gap_r;
   logic [7:0] gap_nxt;
   // trigger level as the counter sees it
   assign trg = (cfg_i.trig_sel ? link_trig_i : ext_trig_i) ^ cfg_i.trig_pol;
   assign free_edge = cfg_i.enable && !cfg_i.cnt_mode && cfg_i.slave == mmpt_pkg::MMPT_SLV_OFF;
   // both-low run of pair 0; saturates so a long idle stays legal
   always_comb
   begin
      gap_nxt = gap_r;
      if (ch_out_o[0] || ch_out_n_o[0])
         gap_nxt = 8'h00;
      else if (gap_r != 8'hff)
         gap_nxt = gap_r + 8'h01;
   end
   always_ff @(posedge ref_clk_i)
      gap_r <= srst_i ? 8'hff : gap_nxt;
   sequence s_edge_wrap;
      free_edge && $changed(count_o) && count_o == 16'h0000 && $past(count_o) == cfg_i.period;
   endsequence
   sequence s_gate_low;
      (cfg_i.slave == mmpt_pkg::MMPT_SLV_GATE && !trg) [*3];
   endsequence
   chk_pair_exclusive: assert property (!(|(ch_out_o[2:0] & ch_out_n_o)))
      else $error("pair outputs high together");
   chk_dead_gap: assert property ($rose(ch_out_o[0]) || $rose(ch_out_n_o[0]) |-> gap_r >= cfg_i.dead_time)
      else $error("dead time too short");
   chk_edge_step: assert property (free_edge && $changed(count_o) |->
      count_o == $past(count_o) + 16'h0001 || count_o == 16'h0000)
      else $error("edge count skipped");
   chk_wrap_update: assert property (s_edge_wrap |-> update_o)
      else $error("no update at wrap");
   chk_center_step: assert property (cfg_i.enable && cfg_i.cnt_mode && $changed(count_o) |->
      count_o == $past(count_o) + 16'h0001 || count_o == $past(count_o) - 16'h0001)
      else $error("center count skipped");
   chk_single_stop: assert property (cfg_i.one_pulse && !cfg_i.slave && update_o |-> ##[0:1] !running_o)
      else $error("single pulse kept running");
   chk_gate_hold: assert property (s_gate_low |-> $stable(count_o))
      else $error("count moved with gate shut");
   chk_reset_trig: assert property (cfg_i.enable && cfg_i.slave == mmpt_pkg::MMPT_SLV_RESET && $rose(trg)
      |-> ##[1:3] update_o)
      else $error("reset trigger lost");
   chk_start_run: assert property (cfg_i.enable && cfg_i.slave == mmpt_pkg::MMPT_SLV_START && !running_o
      && $rose(trg) |-> ##[1:2] running_o)
      else $error("start trigger lost");
   chk_capture_seen: assert property (ch_cfg_i[1].mode == mmpt_pkg::MMPT_CH_CAPTURE && ch_cfg_i[1].both_edges
      && cfg_i.slave != mmpt_pkg::MMPT_SLV_ENC && $changed(ch_in_i[1]) |-> ##[1:3] cap_stb_o[1])
      else $error("capture strobe missing");
endmodule

bind mmpt_timer mmpt_timer_sva u_sva (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .cfg_i(cfg_i), .ch_cfg_i(ch_cfg_i), .ch_in_i(ch_in_i),
   .ext_trig_i(ext_trig_i), .link_trig_i(link_trig_i), .ch_out_o(ch_out_o), .ch_out_n_o(ch_out_n_o),
   .cap_stb_o(cap_stb_o), .count_o(count_o), .running_o(running_o), .update_o(update_o)
);

// ---- tb/mmpt_enc_model.sv ----
// quadrature encoder model driving the timer's channel inputs 0 and 1
// assumes step requests come as one-cycle pulses in the timer clock
`timescale 1ns/1ps
module mmpt_enc_model (
   // clock
   input wire logic ref_clk_i,
   // step request
   input wire logic step_i,
   input wire logic dir_i,
   // phases
   output logic pha_o,
   output logic phb_o
);
   logic [1:0] pos_r = 2'h0;
   logic [1:0] guard_r = 2'h0;
   // one phase moves per step; the guard keeps edges apart
   always @(posedge ref_clk_i)
   begin
      if (guard_r != 2'h0)
         guard_r <= guard_r - 2'h1;
      else if (step_i)
      begin
         pos_r <= dir_i ? pos_r - 2'h1 : pos_r + 2'h1;
         guard_r <= 2'h3;
      end
   end
   // positions 0..3 give a-b levels 00, 01, 11, 10
   assign pha_o = pos_r[1];
   assign phb_o = pos_r[1] ^ pos_r[0];
endmodule

// ---- tb/mmpt_timer_test.sv ----
// self-checking bench for the motor pwm timer
// assumes the package, the design and the encoder model compiled first
`timescale 1ns/1ps
module mmpt_timer_test;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   mmpt_pkg::mmpt_cfg_t cfg = '0;
   mmpt_pkg::mmpt_ch_cfg_t [3:0] chc = '0;
   logic [3:0] ch_drv = 4'h0;
   logic ext_trig = 1'b0;
   logic link_trig = 1'b0;
   logic enc_step = 1'b0;
   logic enc_dir = 1'b0;
   logic pha, phb, dir, running, update, trig_out;
   logic [3:0] ch_in, ch_out, cap_stb;
   logic [2:0] ch_out_n;
   logic [15:0] count;
   logic [15:0] cap_val [4];
   logic [15:0] caps [$];
   int n_mismatch = 0;
   int n_tests = 0;
   // 200 MHz clock
   always #2.5 ref_clk_i = ~ref_clk_i;
   // encoder phases take channel inputs 0 and 1 in encoder mode
   assign ch_in = (cfg.slave == mmpt_pkg::MMPT_SLV_ENC) ? {ch_drv[3:2], phb, pha} : ch_drv;
   // capture log for the width scenario
   always @(posedge ref_clk_i)
      if (cap_stb[1] === 1'b1)
         caps.push_back(cap_val[1]);
   mmpt_timer dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .cfg_i(cfg), .ch_cfg_i(chc), .ch_in_i(ch_in),
      .ext_trig_i(ext_trig), .link_trig_i(link_trig), .ch_out_o(ch_out), .ch_out_n_o(ch_out_n),
      .cap_val_o(cap_val), .cap_stb_o(cap_stb), .count_o(count), .dir_o(dir), .running_o(running),
      .update_o(update), .trig_out_o(trig_out));
   mmpt_enc_model u_enc (.ref_clk_i(ref_clk_i), .step_i(enc_step), .dir_i(enc_dir), .pha_o(pha), .phb_o(phb));
   task automatic give_verdict;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   // reset, then a fresh configuration the cycle after release
   task automatic setup(input mmpt_pkg::mmpt_cfg_t c, input mmpt_pkg::mmpt_ch_cfg_t [3:0] cc);
      tick(1);
      srst_i = 1'b1;
      cfg = '0;
      chc = cc;
      ch_drv = 4'h0;
      tick(2);
      srst_i = 1'b0;
      tick(1);
      cfg = c;
   endtask
   task automatic wait_upd(input int lim);
      for (int i = 0; i < lim && update !== 1'b1; i++)
         tick(1);
   endtask
   task automatic steps(input int n, input logic d);
      enc_dir = d;
      repeat (n)
      begin
         enc_step = 1'b1;
         tick(1);
         enc_step = 1'b0;
         tick(3);
      end
      tick(4);
   endtask
   task automatic t_edge;
      mmpt_pkg::mmpt_cfg_t c = '0;
      c.enable = 1'b1;
      c.period = 16'h0002;
      setup(c, '0);
      tick(1);
      chk("running", 16'h0001, 16'(running));
      for (int i = 1; i <= 3; i++)
      begin
         tick(1);
         chk("edge count", 16'(i % 3), count);
         chk("edge update", 16'(i == 3), 16'(update));
      end
   endtask
   // up to the top, back down through zero; update pulses on the step that leaves each turn
   task automatic t_center;
      mmpt_pkg::mmpt_cfg_t c = '0;
      logic [15:0] ex [7] = '{16'h1, 16'h2, 16'h3, 16'h2, 16'h1, 16'h0, 16'h1};
      c.enable = 1'b1;
      c.cnt_mode = mmpt_pkg::MMPT_CENTER;
      c.period = 16'h0003;
      setup(c, '0);
      tick(1);
      for (int i = 0; i < 7; i++)
      begin
         tick(1);
         chk("center count", ex[i], count);
         chk("center update", 16'(i == 3 || i == 6), 16'(update));
      end
   endtask
   task automatic t_one_pulse;
      mmpt_pkg::mmpt_cfg_t c = '0;
      c.enable = 1'b1;
      c.one_pulse = 1'b1;
      c.period = 16'h0003;
      setup(c, '0);
      wait_upd(20);
      chk("pulse update", 16'h0001, 16'(update));
      tick(6);
      chk("pulse stop", 16'h0000, 16'(running));
      chk("pulse count", 16'h0000, count);
   endtask
   // three pwm pairs plus a toggling compare channel beside them
   task automatic t_pwm;
      mmpt_pkg::mmpt_cfg_t c = '0;
      mmpt_pkg::mmpt_ch_cfg_t [3:0] cc = '0;
      logic [2:0] hi = 3'h0;
      logic [2:0] lo = 3'h0;
      logic last = 1'b0;
      int tog = 0;
      c.enable = 1'b1;
      // every phase outlasts dead time plus one, else the short side is swallowed
      c.period = 16'h000b;
      c.dead_time = 8'h02;
      for (int i = 0; i < 3; i++)
      begin
         cc[i].mode = mmpt_pkg::MMPT_CH_PWM;
         cc[i].cmp = 16'(5 + i);
      end
      cc[2].pol = 1'b1;
      cc[3].mode = mmpt_pkg::MMPT_CH_COMPARE;
      cc[3].cmp = 16'h0005;
      setup(c, cc);
      for (int n = 0; n < 200; n++)
      begin
         tick(1);
         chk("pair overlap", 16'h0000, 16'(ch_out[2:0] & ch_out_n));
         hi = hi | ch_out[2:0];
         lo = lo | ch_out_n;
         tog += (ch_out[3] !== last);
         last = ch_out[3];
      end
      chk("high sides", 16'h0007, 16'(hi));
      chk("low sides", 16'h0007, 16'(lo));
      chk("compare toggles", 16'h0001, 16'(tog >= 10));
   endtask
   // 50-cycle pulse at 5 clocks a tick spans 10 counts
   task automatic t_capture;
      mmpt_pkg::mmpt_cfg_t c = '0;
      mmpt_pkg::mmpt_ch_cfg_t [3:0] cc = '0;
      c.enable = 1'b1;
      c.period = 16'hffff;
      c.prescale = 16'h0004;
      cc[0].pol = 1'b1;
      cc[1].both_edges = 1'b1;
      setup(c, cc);
      tick(7);
      caps.delete();
      ch_drv[1:0] = 2'h3;
      tick(50);
      // channel 0 takes falling edges only, so the rise leaves it at reset
      chk("fall only", mmpt_pkg::CNT_RST, cap_val[0]);
      ch_drv[1:0] = 2'h0;
      tick(6);
      chk("captures", 16'h0002, 16'(caps.size()));
      if (caps.size() == 2)
      begin
         chk("width", 16'h000a, caps[1] - caps[0]);
         chk("fall capture", caps[1], cap_val[0]);
      end
   endtask
   task automatic t_gate;
      mmpt_pkg::mmpt_cfg_t c = '0;
      c.enable = 1'b1;
      c.slave = mmpt_pkg::MMPT_SLV_GATE;
      c.period = 16'h0064;
      setup(c, '0);
      tick(20);
      chk("gate shut", 16'h0000, count);
      ext_trig = 1'b1;
      tick(10);
      ext_trig = 1'b0;
      chk("gate open", 16'h0001, 16'(count >= 16'h0008 && count <= 16'h000b));
   endtask
   // reset trigger arrives over the link from another timer
   task automatic t_reset_trig;
      mmpt_pkg::mmpt_cfg_t c = '0;
      c.enable = 1'b1;
      c.slave = mmpt_pkg::MMPT_SLV_RESET;
      c.trig_sel = 1'b1;
      c.period = 16'h00ff;
      setup(c, '0);
      tick(40);
      link_trig = 1'b1;
      wait_upd(4);
      chk("reset update", 16'h0001, 16'(update));
      chk("link out", 16'h0001, 16'(trig_out));
      chk("reset count", 16'h0001, 16'(count <= 16'h0001));
      link_trig = 1'b0;
   endtask
   // inverted trigger: the falling pin level starts the count
   task automatic t_start;
      mmpt_pkg::mmpt_cfg_t c = '0;
      c.enable = 1'b1;
      c.slave = mmpt_pkg::MMPT_SLV_START;
      c.trig_pol = 1'b1;
      c.period = 16'h0064;
      ext_trig = 1'b1;
      setup(c, '0);
      tick(10);
      chk("start wait", 16'h0000, 16'(running));
      ext_trig = 1'b0;
      tick(3);
      chk("start run", 16'h0001, 16'(running));
   endtask
   task automatic t_encoder;
      mmpt_pkg::mmpt_cfg_t c = '0;
      c.enable = 1'b1;
      c.slave = mmpt_pkg::MMPT_SLV_ENC;
      c.period = 16'h0064;
      setup(c, '0);
      steps(8, 1'b0);
      chk("enc up", 16'h0008, count);
      chk("enc dir up", 16'h0000, 16'(dir));
      steps(3, 1'b1);
      chk("enc down", 16'h0005, count);
      chk("enc dir down", 16'h0001, 16'(dir));
      steps(6, 1'b1);
      chk("enc wrap", 16'h0064, count);
   endtask
   // watchdog, well past the expected run length
   initial
   begin
      #50000;
      n_mismatch++;
      give_verdict();
   end
   initial
   begin
      tick(8);
      srst_i = 1'b0;
      t_edge();
      t_center();
      t_one_pulse();
      t_pwm();
      t_capture();
      t_gate();
      t_reset_trig();
      t_start();
      t_encoder();
      give_verdict();
   end
endmodule
